// *** src/kbi_params.svh ***
`ifndef KBI_PARAMS_SVH
`define KBI_PARAMS_SVH
`define ADDR_STATUS_CONTROL 2'h0
`define ADDR_PIN_ENABLE 2'h1
`define ADDR_POLARITY_SELECT 2'h2
`define BIT_DETECT_MODE 0
`define BIT_IRQ_ENABLE 1
`define BIT_FLAG_ACK 2
`define BIT_EVENT_FLAG 3
`define RESET_BYTE 8'h00
`endif

// *** src/kbi_pkg.sv ***
package kbi_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] reg_addr_t;
endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    // stable sampled level
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // change accepted once second and third stage agree
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            level <= 1'b0;
        else if (s2 == s3)
            level <= s3;
    end
endmodule

// *** src/keyboard_interrupt_unit.sv ***
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`include "kbi_params.svh"
module keyboard_interrupt_unit
#(
    parameter int PINS = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire kbi_pkg::reg_addr_t address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // key inputs
    input wire logic [PINS-1:0] key_input_pin,
    // pull resistor selection, 1 means pulldown
    output logic [PINS-1:0] pull_select_down,
    // interrupt request to the cpu
    output logic irq
);
    import kbi_pkg::*;

    logic [PINS-1:0] pin_enable_reg;
    logic [PINS-1:0] polarity_select_reg;
    logic detect_level_mode;
    logic irq_enable;
    logic event_flag;
    logic [PINS-1:0] synced;
    logic [PINS-1:0] prev_active;
    logic armed;
    logic [PINS-1:0] active;
    logic any_active;
    logic edge_seen;
    logic access_done;
    logic wr_go;
    logic rd_go;
    logic flag_ack;
    logic next_flag;

    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_sync
            pin_sync u_pin_sync
            (
                .clk(clk),
                .rst(rst),
                .pin(key_input_pin[g]),
                .level(synced[g])
            );
        end
    endgenerate

    // one wait state per access, then acknowledge for a single cycle;
    // waitrequest is the flop itself so the bus sees a glitch-free output
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            waitrequest <= 1'b1;
        else
            waitrequest <= !((read || write) && waitrequest);
    end
    assign access_done = !waitrequest;
    assign wr_go = write && access_done;
    assign rd_go = read && access_done;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_enable_reg <= `RESET_BYTE;
            polarity_select_reg <= `RESET_BYTE;
            detect_level_mode <= 1'b0;
            irq_enable <= 1'b0;
        end
        else if (wr_go)
        begin
            case (address)
                `ADDR_STATUS_CONTROL:
                begin
                    detect_level_mode <= writedata[`BIT_DETECT_MODE];
                    irq_enable <= writedata[`BIT_IRQ_ENABLE];
                end
                `ADDR_PIN_ENABLE: pin_enable_reg <= writedata[PINS-1:0];
                `ADDR_POLARITY_SELECT: polarity_select_reg <= writedata[PINS-1:0];
                default: ;
            endcase
        end
    end

    assign flag_ack = wr_go && (address == `ADDR_STATUS_CONTROL)
        && writedata[`BIT_FLAG_ACK];

    // asserted sense per pin, masked by enable
    assign active = (synced ~^ polarity_select_reg) & pin_enable_reg;
    assign any_active = |active;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_active <= '0;
        else
            prev_active <= active;
    end

    // rearm only once every enabled input is deasserted
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            armed <= 1'b0;
        else if (!any_active)
            armed <= 1'b1;
        else if (edge_seen)
            armed <= 1'b0;
    end

    // deasserted then asserted on consecutive cycles
    assign edge_seen = armed && |(active & ~prev_active);

    // set wins over acknowledge
    always_comb
    begin
        next_flag = event_flag;
        if (flag_ack && (!detect_level_mode || !any_active))
            next_flag = 1'b0;
        if (edge_seen)
            next_flag = 1'b1;
        if (detect_level_mode && any_active)
            next_flag = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            event_flag <= 1'b0;
        else
            event_flag <= next_flag;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= next_flag && irq_enable;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pull_select_down <= '0;
        else
            pull_select_down <= polarity_select_reg;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            readdata <= '0;
        else if (read && !access_done)
        begin
            case (address)
                `ADDR_STATUS_CONTROL: readdata <= {28'h0000000, event_flag, 1'b0,
                    irq_enable, detect_level_mode};
                `ADDR_PIN_ENABLE: readdata <= {{(32-PINS){1'b0}}, pin_enable_reg};
                `ADDR_POLARITY_SELECT: readdata <= {{(32-PINS){1'b0}}, polarity_select_reg};
                default: readdata <= '0;
            endcase
        end
    end

    property p_edge_sets_flag;
        @(posedge clk) disable iff (rst) edge_seen |=> event_flag;
    endproperty
    a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("edge lost");

    property p_level_holds;
        @(posedge clk) disable iff (rst) (detect_level_mode && any_active) |=> event_flag;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level lost");

    property p_ack_edge;
        @(posedge clk) disable iff (rst)
            (flag_ack && !detect_level_mode && !edge_seen) |=> !event_flag;
    endproperty
    a_ack_edge: assert property (p_ack_edge) else $error("ack failed");

    property p_ack_level;
        @(posedge clk) disable iff (rst)
            (flag_ack && detect_level_mode && !any_active && !edge_seen) |=> !event_flag;
    endproperty
    a_ack_level: assert property (p_ack_level) else $error("ack failed");

    property p_flag_cause;
        @(posedge clk) disable iff (rst)
            $rose(event_flag) |-> $past(edge_seen) || ($past(detect_level_mode) && $past(any_active));
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag uncaused");

    property p_irq_gate;
        @(posedge clk) disable iff (rst) irq == (event_flag && $past(irq_enable));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq gate");

    property p_no_rearm;
        @(posedge clk) disable iff (rst) edge_seen |=> !edge_seen;
    endproperty
    a_no_rearm: assert property (p_no_rearm) else $error("rearmed");

    property p_disabled;
        @(posedge clk) disable iff (rst) edge_seen |-> |pin_enable_reg;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled edge");

    property p_wait;
        @(posedge clk) disable iff (rst) (read || write) |-> ##[0:1] !waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("no answer");

    // bus timing and readback checks
    property p_ack_single;
        @(posedge clk) disable iff (rst) !waitrequest |=> waitrequest;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("long acknowledge");

    property p_ack_zero;
        @(posedge clk) disable iff (rst)
            (rd_go && address == `ADDR_STATUS_CONTROL) |-> !readdata[`BIT_FLAG_ACK];
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("ack bit read");

    property p_mode_read;
        @(posedge clk) disable iff (rst) (rd_go && address == `ADDR_STATUS_CONTROL)
            |-> readdata[`BIT_DETECT_MODE] == detect_level_mode;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode readback");

    property p_read_enable;
        @(posedge clk) disable iff (rst)
            (rd_go && address == `ADDR_PIN_ENABLE) |-> readdata[PINS-1:0] == pin_enable_reg;
    endproperty
    a_read_enable: assert property (p_read_enable) else $error("enable readback");

    property p_read_pol;
        @(posedge clk) disable iff (rst) (rd_go && address == `ADDR_POLARITY_SELECT)
            |-> readdata[PINS-1:0] == polarity_select_reg;
    endproperty
    a_read_pol: assert property (p_read_pol) else $error("polarity readback");

    property p_read_upper;
        @(posedge clk) disable iff (rst) rd_go |-> readdata[31:PINS] == '0;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper bits set");

    // detection, acknowledge, request and pull select checks
    property p_ack_blocked;
        @(posedge clk) disable iff (rst)
            (flag_ack && detect_level_mode && any_active) |=> event_flag;
    endproperty
    a_ack_blocked: assert property (p_ack_blocked) else $error("ack not blocked");

    property p_flag_write;
        @(posedge clk) disable iff (rst)
            (wr_go && !flag_ack && !edge_seen && !(detect_level_mode && any_active))
            |=> $stable(event_flag);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag written");

    property p_edge_mode;
        @(posedge clk) disable iff (rst)
            (!detect_level_mode && !edge_seen) |=> !$rose(event_flag);
    endproperty
    a_edge_mode: assert property (p_edge_mode) else $error("flag without edge");

    property p_no_enable;
        @(posedge clk) disable iff (rst)
            (pin_enable_reg == '0 && !flag_ack) |=> $stable(event_flag);
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("flag while disabled");

    property p_rearm;
        @(posedge clk) disable iff (rst) (!armed && !any_active) |=> armed;
    endproperty
    a_rearm: assert property (p_rearm) else $error("not rearmed");

    property p_irq_follows;
        @(posedge clk) disable iff (rst) (irq_enable && edge_seen) |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

    property p_irq_masked;
        @(posedge clk) disable iff (rst) !irq_enable |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq not masked");

    property p_pull_follow;
        @(posedge clk) disable iff (rst) pull_select_down == $past(polarity_select_reg);
    endproperty
    a_pull_follow: assert property (p_pull_follow) else $error("pull select");

    // main scenarios reached by the bench
    c_edge: cover property (@(posedge clk) disable iff (rst) edge_seen);
    c_level: cover property (@(posedge clk) disable iff (rst) detect_level_mode && any_active);
    c_ack: cover property (@(posedge clk) disable iff (rst) flag_ack && event_flag);
    c_read: cover property (@(posedge clk) disable iff (rst) rd_go);
    c_blocked: cover property (@(posedge clk) disable iff (rst)
        flag_ack && detect_level_mode && any_active);
endmodule

// *** tb/key_switch_model.sv ***
`timescale 1ns/1ns
module key_switch_model
(
    // clock
    input wire logic clk,
    // levels asked for by the scenario
    input wire logic [7:0] want,
    // key lines
    output logic [7:0] pins
);
    // lines follow the scenario one edge later; the bench keeps them idle
    // until the pins are enabled
    always @(posedge clk)
        pins <= want;
endmodule

// *** tb/keyboard_interrupt_unit_bench.sv ***
`timescale 1ns/1ns
`include "kbi_params.svh"
module keyboard_interrupt_unit_bench;
    import kbi_pkg::*;
    typedef struct packed {logic m; byte_t p; byte_t e; byte_t i; byte_t a; logic f;} row_t;
    logic clk;
    logic rst;
    logic read;
    logic write;
    reg_addr_t address;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [7:0] want;
    logic [7:0] pins;
    logic [7:0] pull_select_down;
    logic irq;
    logic [31:0] d;
    int n_errors;
    int comparisons;
    int cycles;
    // mode, polarity, enable, idle, active, flag
    row_t rows [4] = '{'{1'b0, 8'h00, 8'h01, 8'hFF, 8'hFE, 1'b1},
        '{1'b0, 8'h01, 8'h01, 8'h00, 8'h01, 1'b1},
        '{1'b0, 8'h00, 8'h02, 8'hFF, 8'hFE, 1'b0},
        '{1'b1, 8'hFF, 8'h80, 8'h00, 8'h80, 1'b1}};

    keyboard_interrupt_unit #(.PINS(8)) u_keyboard_interrupt_unit
    (
        .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .key_input_pin(pins), .pull_select_down(pull_select_down), .irq(irq)
    );
    key_switch_model u_key_switch_model (.clk(clk), .want(want), .pins(pins));

    task test_done;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic rd, input reg_addr_t a, input byte_t v);
        @(posedge clk);
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= {24'h000000, v};
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task rdc(input reg_addr_t a, input byte_t exp);
        bus(1'b1, a, 8'h00);
        check(d, exp);
    endtask
    task pause;
        repeat (8) @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            test_done;
        end
    end
    initial
    begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 2'h0;
        writedata = 32'h00000000;
        want = 8'hFF;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[k])
        begin
            want <= rows[k].i;
            bus(1'b0, `ADDR_STATUS_CONTROL, 8'h00);
            bus(1'b0, `ADDR_POLARITY_SELECT, rows[k].p);
            bus(1'b0, `ADDR_PIN_ENABLE, rows[k].e);
            pause;
            bus(1'b0, `ADDR_STATUS_CONTROL, {5'h00, 2'h2, rows[k].m});
            bus(1'b0, `ADDR_STATUS_CONTROL, {5'h00, 2'h1, rows[k].m});
            check(pull_select_down, rows[k].p);
            rdc(`ADDR_STATUS_CONTROL, {6'h00, 1'b1, rows[k].m});
            want <= rows[k].a;
            pause;
            check(irq, rows[k].f);
            rdc(`ADDR_STATUS_CONTROL, {4'h0, rows[k].f, 2'h1, rows[k].m});
            want <= rows[k].i;
            pause;
            bus(1'b0, `ADDR_STATUS_CONTROL, {5'h00, 2'h3, rows[k].m});
            rdc(`ADDR_STATUS_CONTROL, {6'h00, 1'b1, rows[k].m});
            $display("row %0d done", k);
        end
        want <= 8'hFF;
        bus(1'b0, `ADDR_POLARITY_SELECT, 8'h00);
        bus(1'b0, `ADDR_PIN_ENABLE, 8'h03);
        pause;
        bus(1'b0, `ADDR_STATUS_CONTROL, 8'h06);
        want <= 8'hFE;
        pause;
        bus(1'b0, `ADDR_STATUS_CONTROL, 8'h06);
        rdc(`ADDR_STATUS_CONTROL, 8'h02);
        want <= 8'hFC;
        pause;
        rdc(`ADDR_STATUS_CONTROL, 8'h02);
        want <= 8'hFF;
        pause;
        want <= 8'hFD;
        pause;
        rdc(`ADDR_STATUS_CONTROL, 8'h0A);
        bus(1'b0, `ADDR_STATUS_CONTROL, 8'h08);
        rdc(`ADDR_STATUS_CONTROL, 8'h08);
        check(irq, 1'b0);
        bus(1'b0, `ADDR_STATUS_CONTROL, 8'h07);
        pause;
        bus(1'b0, `ADDR_STATUS_CONTROL, 8'h07);
        rdc(`ADDR_STATUS_CONTROL, 8'h0B);
        check(irq, 1'b1);
        $display("edge rearm and level test done");
        bus(1'b0, `ADDR_POLARITY_SELECT, 8'h5A);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check(irq, 1'b0);
        check(pull_select_down, 8'h00);
        rdc(`ADDR_STATUS_CONTROL, 8'h00);
        rdc(`ADDR_PIN_ENABLE, 8'h00);
        rdc(`ADDR_POLARITY_SELECT, 8'h00);
        bus(1'b0, 2'h3, 8'hFF);
        rdc(2'h3, 8'h00);
        $display("reset and unmapped test done");
        test_done;
    end
endmodule
